//--- verilog/sem_host_pkg.sv
// Package for the semaphore port controller: constants, types, behaviour list
// Behaviour
// (R1) Device offers eight semaphore flags separate from the RAM array.
// (R2) Each flag has one request latch per port feeding one owner element.
// (R3) First side presenting zero reads low; the other side reads high.
// (R4) Ownership holds until the owner writes one; other side cannot release.
// (R5) Owner releasing with the other side pending hands the token over.
// (R6) New owner stays low until it writes one to its own latch.
// (R7) Concurrent requests grant the token to exactly one port.
// (R8) The earlier zero-write wins the token.
// (R9) Same-instant requests go to either port, but only one.
// (R10) Winner reads back zero; loser reads back one.
// (R11) Host claims by writing zero first, then reading back.
// (R12) After failure host re-reads or writes one to withdraw.
// (R13) Host writes one to a flag it holds or requested but no longer needs.
// (R14) Device does not initialise request latches at power-up.
// (R15) Host writes one to every flag at start-up to free them.
// (R16) Only the lowest data line carries request (zero) or release (one).
// (R17) Select low picks semaphore space; low three address lines pick flag.
// (R18) Device replicates the flag onto every data output bit.
// (R19) Read latches on select and output enable; deassert between reads.
// (R20) A clocked device synchronises and edge-detects strobes.
`default_nettype none
package sem_host_pkg;
    localparam int FLAG_COUNT   = 8;                                  // (R1)
    localparam int INDEX_W      = 3;                                  // (R17)
    localparam int ADDR_W       = 12;
    localparam int DATA_W       = 16;
    localparam logic DATA_REQ   = 1'b0;                               // (R16)
    localparam logic DATA_REL   = 1'b1;                               // (R16)
    localparam real  T_SETUP_NS = 20.0;
    localparam real  T_PULSE_NS = 20.0;
    localparam real  T_CLK_NS   = 4.0;
    localparam int SETUP_CYC = (int'($ceil(T_SETUP_NS / T_CLK_NS)) < 1) ? 1
                             : int'($ceil(T_SETUP_NS / T_CLK_NS));
    localparam int PULSE_CYC = (int'($ceil(T_PULSE_NS / T_CLK_NS)) < 1) ? 1
                             : int'($ceil(T_PULSE_NS / T_CLK_NS));
    localparam int CNT_W = 4;
    localparam int SYNC_LAST = 2;

    typedef enum logic [1:0] {
        OP_RELEASE,
        OP_CLAIM,
        OP_POLL,
        OP_INIT
    } sem_op_e;

    typedef struct packed {
        sem_op_e             op;
        logic [INDEX_W-1:0]  flagIndex;
    } sem_cmd_s;

    typedef struct packed {
        logic                won;
        logic                flagValue;
        logic [INDEX_W-1:0]  flagIndex;
    } sem_rsp_s;

    typedef struct packed {
        logic                semSelN;
        logic                outEnN;
        logic                writeN;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   dataOut;
        logic                dataOe;
    } sem_pins_s;
endpackage
`default_nettype wire

//--- verilog/sem_owner_table.sv
// Small memory of which flags this port holds or has requested
`default_nettype none
module sem_owner_table (
    // Clock and reset
    input  wire logic                                clk_sys,
    input  wire logic                                resetn,
    // Update port
    input  wire logic                                wrEn,
    input  wire logic [sem_host_pkg::INDEX_W-1:0]    wrIndex,
    input  wire logic                                wrHeld,
    input  wire logic                                wrPending,
    // State out
    output logic [sem_host_pkg::FLAG_COUNT-1:0]      held,
    output logic [sem_host_pkg::FLAG_COUNT-1:0]      pending
);
    logic [sem_host_pkg::FLAG_COUNT-1:0] held_reg;
    logic [sem_host_pkg::FLAG_COUNT-1:0] held_next;
    logic [sem_host_pkg::FLAG_COUNT-1:0] pend_reg;
    logic [sem_host_pkg::FLAG_COUNT-1:0] pend_next;

    always_comb begin
        held_next = held_reg;
        pend_next = pend_reg;
        if (wrEn) begin
            held_next[wrIndex] = wrHeld;
            pend_next[wrIndex] = wrPending;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            held_reg <= '0;
            pend_reg <= '0;
        end else begin
            held_reg <= held_next;
            pend_reg <= pend_next;
        end
    end

    assign held    = held_reg;
    assign pending = pend_reg;
endmodule
`default_nettype wire

//--- verilog/sem_host.sv
// Port controller that claims, polls and releases the semaphore flags
`default_nettype none
module sem_host (
    // Clock and reset
    input  wire logic                                clk_sys,
    input  wire logic                                resetn,
    // Command
    input  wire logic                                cmdValid,
    output logic                                     cmdReady,
    input  wire sem_host_pkg::sem_cmd_s              cmd,
    // Response
    output logic                                     rspValid,
    output sem_host_pkg::sem_rsp_s                   rsp,
    // Flag state
    output logic [sem_host_pkg::FLAG_COUNT-1:0]      heldFlags,
    output logic [sem_host_pkg::FLAG_COUNT-1:0]      pendingFlags,
    output logic                                     initDone,
    // Device pins
    output sem_host_pkg::sem_pins_s                  pins,
    input  wire logic [sem_host_pkg::DATA_W-1:0]     dataIn
);
    typedef enum logic [3:0] {
        S_INIT_SETUP,
        S_INIT_WRITE,
        S_IDLE,
        S_WR_SETUP,
        S_WR_PULSE,
        S_GAP,
        S_RD_SETUP,
        S_RD_WAIT,
        S_RD_SAMPLE,
        S_DONE
    } state_e;

    state_e                              state_reg;
    state_e                              state_next;
    logic [sem_host_pkg::CNT_W-1:0]      cnt_reg;
    logic [sem_host_pkg::CNT_W-1:0]      cnt_next;
    sem_host_pkg::sem_cmd_s              cur_reg;
    sem_host_pkg::sem_cmd_s              cur_next;
    sem_host_pkg::sem_pins_s             pins_reg;
    sem_host_pkg::sem_pins_s             pins_next;
    sem_host_pkg::sem_rsp_s              rsp_reg;
    sem_host_pkg::sem_rsp_s              rsp_next;
    logic                                rspValid_reg;
    logic                                rspValid_next;
    logic                                initDone_reg;
    logic                                initDone_next;
    logic [sem_host_pkg::INDEX_W-1:0]    initIdx_reg;
    logic [sem_host_pkg::INDEX_W-1:0]    initIdx_next;
    logic [sem_host_pkg::DATA_W-1:0]     din1_reg;
    logic [sem_host_pkg::DATA_W-1:0]     din2_reg;
    logic [sem_host_pkg::DATA_W-1:0]     din3_reg;
    logic                                tabWr;
    logic                                tabHeld;
    logic                                tabPend;
    logic [sem_host_pkg::INDEX_W-1:0]    tabIdx;
    logic [sem_host_pkg::FLAG_COUNT-1:0] held;
    logic [sem_host_pkg::FLAG_COUNT-1:0] pending;

    localparam logic [sem_host_pkg::CNT_W-1:0] SETUP_LAST =
        sem_host_pkg::CNT_W'(sem_host_pkg::SETUP_CYC - 1);
    localparam logic [sem_host_pkg::CNT_W-1:0] PULSE_LAST =
        sem_host_pkg::CNT_W'(sem_host_pkg::PULSE_CYC - 1);
    localparam logic [sem_host_pkg::CNT_W-1:0] SYNC_END =
        sem_host_pkg::CNT_W'(sem_host_pkg::SYNC_LAST);
    localparam logic [sem_host_pkg::INDEX_W-1:0] LAST_IDX =
        sem_host_pkg::INDEX_W'(sem_host_pkg::FLAG_COUNT - 1);

    // Idle pin state: nothing selected, bus released
    function automatic sem_host_pkg::sem_pins_s idlePins();
        sem_host_pkg::sem_pins_s p;
        p = '0;
        p.semSelN = 1'b1;
        p.outEnN  = 1'b1;
        p.writeN  = 1'b1;
        return p;
    endfunction

    // Address with flag index in low bits, others zero
    function automatic logic [sem_host_pkg::ADDR_W-1:0] flagAddr(
        input logic [sem_host_pkg::INDEX_W-1:0] idx);
        return {{(sem_host_pkg::ADDR_W-sem_host_pkg::INDEX_W){1'b0}},
                idx};                                                 // (R17)
    endfunction

    // Write data with the request bit on the lowest line
    function automatic logic [sem_host_pkg::DATA_W-1:0] flagData(
        input logic bitVal);
        return {{(sem_host_pkg::DATA_W-1){1'b0}}, bitVal};            // (R16)
    endfunction

    sem_owner_table u_table (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .wrEn      (tabWr),
        .wrIndex   (tabIdx),
        .wrHeld    (tabHeld),
        .wrPending (tabPend),
        .held      (held),
        .pending   (pending)
    );

    // Data input synchroniser
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            din1_reg <= '0;
            din2_reg <= '0;
            din3_reg <= '0;
        end else begin
            din1_reg <= dataIn;
            din2_reg <= din1_reg;
            din3_reg <= din2_reg;
        end
    end

    always_comb begin
        state_next    = state_reg;
        cnt_next      = cnt_reg;
        cur_next      = cur_reg;
        pins_next     = pins_reg;
        rsp_next      = rsp_reg;
        rspValid_next = 1'b0;
        initDone_next = initDone_reg;
        initIdx_next  = initIdx_reg;
        tabWr         = 1'b0;
        tabIdx        = cur_reg.flagIndex;
        tabHeld       = 1'b0;
        tabPend       = 1'b0;
        case (state_reg)
            // Release every flag at start-up
            S_INIT_SETUP: begin
                pins_next.semSelN = 1'b0;
                pins_next.addr    = flagAddr(initIdx_reg);            // (R15)
                pins_next.dataOut = flagData(sem_host_pkg::DATA_REL); // (R14)
                pins_next.dataOe  = 1'b1;
                pins_next.writeN  = 1'b1;
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg == SETUP_LAST) begin
                    cnt_next = '0;
                    pins_next.writeN = 1'b0;
                    state_next = S_INIT_WRITE;
                end
            end
            S_INIT_WRITE: begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg == PULSE_LAST) begin
                    cnt_next  = '0;
                    pins_next = idlePins();
                    tabWr     = 1'b1;                                 // (R13)
                    tabIdx    = initIdx_reg;
                    if (initIdx_reg == LAST_IDX) begin
                        initDone_next = 1'b1;
                        state_next = S_IDLE;
                    end else begin
                        initIdx_next = initIdx_reg + 1'b1;
                        state_next = S_INIT_SETUP;
                    end
                end
            end
            S_IDLE: begin
                if (cmdValid) begin
                    cur_next = cmd;
                    cnt_next = '0;
                    pins_next.semSelN = 1'b0;
                    pins_next.addr    = flagAddr(cmd.flagIndex);
                    if (cmd.op == sem_host_pkg::OP_POLL) begin
                        state_next = S_RD_SETUP;                      // (R12)
                    end else if (cmd.op == sem_host_pkg::OP_INIT) begin
                        initIdx_next  = '0;
                        initDone_next = 1'b0;
                        pins_next     = idlePins();
                        state_next    = S_INIT_SETUP;
                    end else begin
                        pins_next.dataOe  = 1'b1;
                        pins_next.dataOut = flagData(
                            cmd.op == sem_host_pkg::OP_CLAIM ?
                            sem_host_pkg::DATA_REQ : sem_host_pkg::DATA_REL);
                        state_next = S_WR_SETUP;                      // (R11)
                    end
                end
            end
            S_WR_SETUP: begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg == SETUP_LAST) begin
                    cnt_next = '0;
                    pins_next.writeN = 1'b0;
                    state_next = S_WR_PULSE;
                end
            end
            S_WR_PULSE: begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg == PULSE_LAST) begin
                    cnt_next  = '0;
                    pins_next = idlePins();                           // (R19)
                    if (cur_reg.op == sem_host_pkg::OP_RELEASE) begin
                        tabWr = 1'b1;                                 // (R13)
                        tabHeld = 1'b0;
                        tabPend = 1'b0;
                        rsp_next.won       = 1'b0;
                        rsp_next.flagValue = sem_host_pkg::DATA_REL;
                        rsp_next.flagIndex = cur_reg.flagIndex;
                        state_next = S_DONE;
                    end else begin
                        state_next = S_GAP;
                    end
                end
            end
            S_GAP: begin
                pins_next.semSelN = 1'b0;
                pins_next.addr    = flagAddr(cur_reg.flagIndex);
                state_next = S_RD_SETUP;                              // (R11)
            end
            S_RD_SETUP: begin
                pins_next.outEnN = 1'b0;
                state_next = S_RD_WAIT;
            end
            S_RD_WAIT: begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg == PULSE_LAST) begin
                    cnt_next = '0;
                    state_next = S_RD_SAMPLE;
                end
            end
            S_RD_SAMPLE: begin
                // Data settled through the synchroniser
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg == SYNC_END) begin
                    cnt_next  = '0;
                    pins_next = idlePins();                           // (R19)
                    tabWr = 1'b1;
                    rsp_next.flagValue = din3_reg[0];                 // (R18)
                    rsp_next.won = (din3_reg[0] == sem_host_pkg::DATA_REQ)
                                && (din2_reg[0] == din3_reg[0]);      // (R10)
                    rsp_next.flagIndex = cur_reg.flagIndex;
                    tabHeld = rsp_next.won;
                    tabPend = !rsp_next.won;                          // (R12)
                    state_next = S_DONE;
                end
            end
            S_DONE: begin
                rspValid_next = 1'b1;
                state_next = S_IDLE;
            end
            default: begin
                pins_next  = idlePins();
                state_next = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_reg    <= S_INIT_SETUP;
            cnt_reg      <= '0;
            cur_reg      <= '0;
            pins_reg     <= idlePins();
            rsp_reg      <= '0;
            rspValid_reg <= 1'b0;
            initDone_reg <= 1'b0;
            initIdx_reg  <= '0;
        end else begin
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            cur_reg      <= cur_next;
            pins_reg     <= pins_next;
            rsp_reg      <= rsp_next;
            rspValid_reg <= rspValid_next;
            initDone_reg <= initDone_next;
            initIdx_reg  <= initIdx_next;
        end
    end

    assign cmdReady     = (state_reg == S_IDLE);
    assign rspValid     = rspValid_reg;
    assign rsp          = rsp_reg;
    assign pins         = pins_reg;
    assign heldFlags    = held;
    assign pendingFlags = pending;
    assign initDone     = initDone_reg;
endmodule
`default_nettype wire

//--- verif/sem_host_chk.sv
// Checker of the port controller's pin and response timing
`default_nettype none
module sem_host_chk (
    // Clock and reset
    input  wire logic                                clk_sys,
    input  wire logic                                resetn,
    // Watched ports
    input  wire logic                                cmdReady,
    input  wire logic                                rspValid,
    input  wire sem_host_pkg::sem_rsp_s              rsp,
    input  wire logic [sem_host_pkg::FLAG_COUNT-1:0] heldFlags,
    input  wire logic                                initDone,
    input  wire sem_host_pkg::sem_pins_s             pins
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    // Claim write phase, then read-back phase
    sequence s_claim_write;
        !pins.writeN && !pins.dataOut[0] ##1 pins.writeN;
    endsequence
    sequence s_read_back;
        ##[1:3] !pins.outEnN;
    endsequence

    chk_write_select: assert property (
        !pins.writeN |-> !pins.semSelN && pins.dataOe)
        else $error("write strobe without select or data drive");
    chk_no_overlap: assert property (
        !(!pins.writeN && !pins.outEnN))
        else $error("write and read strobes overlap");
    chk_claim_order: assert property (
        s_claim_write |-> s_read_back)
        else $error("claim write not followed by read-back");
    chk_write_len: assert property (
        $fell(pins.writeN) |-> (!pins.writeN)[*5] ##1 pins.writeN)
        else $error("write strobe length wrong");
    chk_addr_hold: assert property (
        !pins.writeN |-> $stable(pins.addr) && !pins.semSelN)
        else $error("address moved during write");
    chk_read_idle: assert property (
        rspValid |-> pins.semSelN && pins.outEnN)
        else $error("read strobes still active at response");
    chk_won_low: assert property (
        rspValid && rsp.won |-> !rsp.flagValue)
        else $error("won reported with flag high");
    chk_held_set: assert property (
        rspValid && rsp.won && !rsp.flagValue
            |-> ##[0:2] heldFlags[rsp.flagIndex])
        else $error("won flag not marked held");
    chk_ready_init: assert property (
        cmdReady |-> initDone)
        else $error("command accepted before start-up release");
endmodule
bind sem_host sem_host_chk u_chk (.clk_sys(clk_sys), .resetn(resetn),
    .cmdReady(cmdReady), .rspValid(rspValid), .rsp(rsp),
    .heldFlags(heldFlags), .initDone(initDone), .pins(pins));
`default_nettype wire

//--- verif/sem_dev_model.sv
// Behavioural semaphore device with a bench-driven far port
`default_nettype none
module sem_dev_model (
    // Clock
    input  wire logic                    clk_sys,
    // Near port pins
    input  wire sem_host_pkg::sem_pins_s pins,
    output logic [15:0]                  dataIn,
    // Far port
    input  wire logic                    farWr,
    input  wire logic [2:0]              farIdx,
    input  wire logic                    farBit,
    output logic [7:0]                   nearOwns,
    output logic [7:0]                   farOwns
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] nearLatch = 8'h5a; // Undefined power-up state
    logic [7:0] farLatch  = 8'hc3;
    logic       rdHeld    = 1'b1;
    logic       rdWas     = 1'b0;
    logic       rdOn;
    initial begin
        nearOwns = 8'h00;
        farOwns = 8'h00;
    end
    assign rdOn = !pins.semSelN && !pins.outEnN;
    // Replicated value; inverse of it once released
    assign dataIn = rdOn ? {16{rdHeld}} : {16{!rdHeld}};
    always @(posedge clk_sys) begin
        rdWas <= rdOn;
        if (rdOn && !rdWas)
            rdHeld <= !nearOwns[pins.addr[2:0]];
        if (!pins.semSelN && !pins.writeN)
            nearLatch[pins.addr[2:0]] <= pins.dataOut[0];
        if (farWr)
            farLatch[farIdx] <= farBit;
    end
    always @(posedge clk_sys)
        for (int i = 0; i < 8; i++) begin
            if (nearOwns[i] && nearLatch[i]) begin
                nearOwns[i] <= 1'b0;
                farOwns[i] <= !farLatch[i];
            end else if (farOwns[i] && farLatch[i]) begin
                farOwns[i] <= 1'b0;
                nearOwns[i] <= !nearLatch[i];
            end else if (!nearOwns[i] && !farOwns[i]) begin
                nearOwns[i] <= !nearLatch[i];
                farOwns[i] <= nearLatch[i] && !farLatch[i];
            end
        end
endmodule
`default_nettype wire

//--- verif/dual_port_semaphore_flags_tb_top.sv
// Bench for the semaphore port controller against a device model
`default_nettype none
module dual_port_semaphore_flags_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                    clk_sys  = 1'b0;
    logic                    resetn   = 1'b0;
    logic                    cmdValid = 1'b0;
    sem_host_pkg::sem_cmd_s  cmd      = 5'h00;
    logic                    farWr    = 1'b0;
    logic                    farBit   = 1'b1;
    logic [2:0]              farIdx   = 3'h0;
    logic                    cmdReady, rspValid, initDone;
    sem_host_pkg::sem_rsp_s  rsp;
    sem_host_pkg::sem_pins_s pins;
    logic [7:0]              heldFlags, pendingFlags, nearOwns, farOwns;
    logic [15:0]             dataIn;
    int                      miscompares = 0;
    int                      nTests = 0;

    sem_host i_dut (.clk_sys(clk_sys), .resetn(resetn), .cmdValid(cmdValid),
        .cmdReady(cmdReady), .cmd(cmd), .rspValid(rspValid), .rsp(rsp),
        .heldFlags(heldFlags), .pendingFlags(pendingFlags),
        .initDone(initDone), .pins(pins), .dataIn(dataIn));
    sem_dev_model u_dev (.clk_sys(clk_sys), .pins(pins), .dataIn(dataIn),
        .farWr(farWr), .farIdx(farIdx), .farBit(farBit),
        .nearOwns(nearOwns), .farOwns(farOwns));

    initial begin
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        nTests++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("Comparisons %0d mismatches %0d", nTests, miscompares);
        if (miscompares == 0 && nTests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic run(input sem_host_pkg::sem_op_e op, input logic [2:0] idx);
        int k;
        @(posedge clk_sys);
        cmdValid <= 1'b1;
        cmd <= '{op: op, flagIndex: idx};
        k = 0;
        do begin
            @(negedge clk_sys);
            k++;
        end while (cmdReady !== 1'b1 && k < 500);
        @(posedge clk_sys);
        cmdValid <= 1'b0;
        k = 0;
        do begin
            @(negedge clk_sys);
            k++;
        end while (rspValid !== 1'b1 && k < 100);
        check(rspValid, 1'b1);
        @(negedge clk_sys);
    endtask

    task automatic farWrite(input logic [2:0] idx, input logic b);
        @(posedge clk_sys);
        farWr <= 1'b1;
        farIdx <= idx;
        farBit <= b;
        @(posedge clk_sys);
        farWr <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask

    task automatic t_init;
        int k;
        for (k = 0; k < 8; k++)
            farWrite(k[2:0], 1'b1);
        k = 0;
        while (initDone !== 1'b1 && k < 400) begin
            @(negedge clk_sys);
            k++;
        end
        check(initDone, 1'b1);
        check(nearOwns | farOwns, 8'h00);
        check(heldFlags, 8'h00);
    endtask

    task automatic t_claim_all;
        for (int i = 0; i < 8; i++) begin
            run(sem_host_pkg::OP_CLAIM, i[2:0]);
            check(rsp.won, 1'b1);
            check(rsp.flagValue, 1'b0);
            check(rsp.flagIndex, i[2:0]);
            check(nearOwns, 8'h01 << i);
            check(farOwns, 8'h00);
            check(heldFlags, 8'h01 << i);
            run(sem_host_pkg::OP_RELEASE, i[2:0]);
            check(heldFlags | nearOwns, 8'h00);
        end
    endtask

    task automatic t_contend;
        farWrite(3'h5, 1'b0);
        run(sem_host_pkg::OP_CLAIM, 3'h5);
        check(rsp.won, 1'b0);
        check(rsp.flagValue, 1'b1);
        check(pendingFlags, 8'h20);
        run(sem_host_pkg::OP_POLL, 3'h5);
        check(rsp.flagValue, 1'b1);
        farWrite(3'h5, 1'b1);
        check(nearOwns, 8'h20);
        farWrite(3'h5, 1'b1);
        run(sem_host_pkg::OP_POLL, 3'h5);
        check(rsp.flagValue, 1'b0);
        run(sem_host_pkg::OP_RELEASE, 3'h5);
        check(nearOwns | farOwns, 8'h00);
    endtask

    task automatic t_withdraw;
        farWrite(3'h2, 1'b0);
        run(sem_host_pkg::OP_CLAIM, 3'h2);
        check(pendingFlags, 8'h04);
        run(sem_host_pkg::OP_RELEASE, 3'h2);
        check(pendingFlags, 8'h00);
        farWrite(3'h2, 1'b1);
        check(nearOwns | farOwns, 8'h00);
    endtask

    task automatic t_race;
        fork
            run(sem_host_pkg::OP_CLAIM, 3'h6);
            begin
                wait (pins.writeN === 1'b0);
                farWrite(3'h6, 1'b0);
            end
        join
        check(rsp.won, 1'b1);
        check(nearOwns & farOwns, 8'h00);
        run(sem_host_pkg::OP_RELEASE, 3'h6);
        check(farOwns, 8'h40);
        farWrite(3'h6, 1'b1);
        check(nearOwns | farOwns, 8'h00);
    endtask

    task automatic t_reinit;
        int k;
        run(sem_host_pkg::OP_CLAIM, 3'h1);
        check(heldFlags, 8'h02);
        @(posedge clk_sys);
        cmdValid <= 1'b1;
        cmd <= '{op: sem_host_pkg::OP_INIT, flagIndex: 3'h0};
        @(posedge clk_sys);
        cmdValid <= 1'b0;
        @(negedge clk_sys);
        check(initDone, 1'b0);
        k = 0;
        while (initDone !== 1'b1 && k < 400) begin
            @(negedge clk_sys);
            k++;
        end
        check(initDone, 1'b1);
        check(heldFlags | pendingFlags, 8'h00);
        check(nearOwns | farOwns, 8'h00);
    endtask

    initial begin
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        t_init;
        t_claim_all;
        t_contend;
        t_withdraw;
        t_race;
        t_reinit;
        give_verdict;
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        give_verdict;
    end
endmodule
`default_nettype wire
